/* File: hdl/pshp_link_if.sv */
/*
 Internal link between the port core, the strobe A synchroniser and
 the strobe B generator. Assumes all three share one clock.
*/
`timescale 1ns/10ps
interface pshp_link_if;
    logic strobe_a_in_level;
    logic strobe_a_in_rise;
    logic strobe_a_in_fall;
    logic sb_start;
    logic sb_stop;
    logic sb_pulsed;
    logic sb_polarity;
    logic sb_level;
    modport sync (output strobe_a_in_level, output strobe_a_in_rise, output strobe_a_in_fall);
    modport gen  (input sb_start, input sb_stop, input sb_pulsed,
                  input sb_polarity, output sb_level);
    modport core (input strobe_a_in_level, input strobe_a_in_rise, input strobe_a_in_fall,
                  input sb_level, output sb_start, output sb_stop,
                  output sb_pulsed, output sb_polarity);
endinterface

/* File: hdl/pshp_pkg.sv */
/*
 Constants for the parallel strobe handshake port: register offsets,
 control field positions, reset values and the strobe B pulse length.
 Assumes a 32-bit APB slave with 8-bit byte addresses.
*/
package pshp_pkg;
    ////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  CTRL_OFF     = 8'h00;
    localparam logic [7:0]  PB_DATA_OFF  = 8'h04;
    localparam logic [7:0]  PC_DATA_OFF  = 8'h08;
    localparam logic [7:0]  PC_LATCH_OFF = 8'h0C;
    localparam logic [7:0]  PC_DIR_OFF   = 8'h10;
    localparam logic [7:0]  IRQ_ST_OFF   = 8'h14;
    localparam logic [7:0]  IRQ_MASK_OFF = 8'h18;
    localparam logic [7:0]  MODE_OFF     = 8'h1C;
    ////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int          FLAG_BIT     = 7;
    localparam int          IRQ_EN_BIT   = 6;
    localparam int          OD_BIT       = 5;
    localparam int          FULL_HS_BIT  = 4;
    localparam int          DIR_BIT      = 3;
    localparam int          PULSED_BIT   = 2;
    localparam int          EDGE_BIT     = 1;
    localparam int          POL_BIT      = 0;
    localparam logic [6:0]  CTRL_RESET   = 7'h03;
    ////////////////////////////////////////////////////////////////////
    // Interrupt sources, mode and reset values
    localparam int          IRQ_W        = 2;
    localparam int          SRC_STROBE_A_IN     = 0;
    localparam int          SRC_STROBE_B_OUT     = 1;
    localparam int          SINGLE_BIT   = 0;
    localparam logic [0:0]  MODE_RESET   = 1'h1;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [31:0] WORD_ZERO    = 32'h00000000;
    localparam int          PULSE_CYCLES = 2;
endpackage

/* File: hdl/pshp_strobe_a_in_sync.sv */
/*
 Strobe A synchroniser with edge detection.
 Assumes strobe A may change at any time relative to pclk.
*/
`timescale 1ns/10ps
module pshp_strobe_a_in_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Strobe pin
    input  wire logic strobe_a_in,
    // Edges and level
    pshp_link_if.sync link
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= strobe_a_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign link.strobe_a_in_level = sync_q;
    assign link.strobe_a_in_rise  = sync_q & ~prev_q;
    assign link.strobe_a_in_fall  = ~sync_q & prev_q;
endmodule

/* File: hdl/pshp_strobe_b_gen.sv */
/*
 Strobe B generator: fixed-length pulse or level held until stopped.
 Assumes start is a single-cycle request from the core; stop is held high while single-chip mode is off.
*/
`timescale 1ns/10ps
module pshp_strobe_b_gen #(
    parameter int PULSE = pshp_pkg::PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control and output
    pshp_link_if.gen  link
);
    logic       active_q;
    logic       active_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       out_q;

    always_comb begin
        active_d = active_q;
        cnt_d    = cnt_q;
        if (link.sb_start) begin
            active_d = 1'b1;
            cnt_d    = 4'(PULSE - 1);
        end else if (link.sb_stop) begin
            active_d = 1'b0;
        end else if (active_q && link.sb_pulsed) begin
            if (cnt_q == 4'h0) begin
                active_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
            cnt_q    <= 4'h0;
            out_q    <= 1'b0;
        end else begin
            active_q <= active_d;
            cnt_q    <= cnt_d;
            out_q    <= link.sb_polarity ? active_d : ~active_d;
        end
    end

    assign link.sb_level = out_q;
endmodule

/* File: hdl/pshp_top.sv */
/*
 Parallel strobe handshake port: APB register file, strobe A flag with
 its clearing sequence, port C capture and drive, strobe B control,
 interrupt status and mask.
 Assumes APB master timing on pclk; port C and strobe pins are external.
*/
`timescale 1ns/10ps
module pshp_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Strobes
    input  wire logic        strobe_a_in,
    output logic             strobe_b_out,
    // Port B
    output logic      [7:0]  port_b_out,
    // Port C
    input  wire logic [7:0]  port_c_in,
    output logic      [7:0]  port_c_out,
    output logic      [7:0]  port_c_oe,
    // Interrupt
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////
    // State
    logic [6:0]  ctrl_q;
    logic        flag_q;
    logic        flag_d;
    logic        armed_q;
    logic        armed_d;
    logic [7:0]  pb_q;
    logic [7:0]  pc_data_q;
    logic [7:0]  latch_q;
    logic [7:0]  ddr_q;
    logic [1:0]  st_q;
    logic [1:0]  st_d;
    logic [1:0]  mask_q;
    logic [0:0]  mode_q;
    logic        in_hs_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [7:0]  pc_out_q;
    logic [7:0]  pc_oe_q;
    logic        irq_q;

    pshp_link_if link ();

    ////////////////////////////////////////////////////////////////////
    // Submodules
    pshp_strobe_a_in_sync u_sync (
        .pclk        (pclk),
        .presetn     (presetn),
        .strobe_a_in (strobe_a_in),
        .link        (link.sync)
    );

    pshp_strobe_b_gen #(
        .PULSE (pshp_pkg::PULSE_CYCLES)
    ) u_sb (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (link.gen)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire        setup     = psel & ~penable;
    wire        done      = psel & penable & pready_q;
    wire        wr        = done & pwrite;
    wire        rd        = done & ~pwrite;
    wire        hit_ctrl  = paddr == pshp_pkg::CTRL_OFF;
    wire        hit_pb    = paddr == pshp_pkg::PB_DATA_OFF;
    wire        hit_pc    = paddr == pshp_pkg::PC_DATA_OFF;
    wire        hit_latch = paddr == pshp_pkg::PC_LATCH_OFF;
    wire        hit_ddr   = paddr == pshp_pkg::PC_DIR_OFF;
    wire        hit_st    = paddr == pshp_pkg::IRQ_ST_OFF;
    wire        hit_mask  = paddr == pshp_pkg::IRQ_MASK_OFF;
    wire        hit_mode  = paddr == pshp_pkg::MODE_OFF;
    wire        mapped    = hit_ctrl | hit_pb | hit_pc | hit_latch
                          | hit_ddr | hit_st | hit_mask | hit_mode;

    ////////////////////////////////////////////////////////////////////
    // Mode decode
    // Single-chip gate
    wire        en        = mode_q[pshp_pkg::SINGLE_BIT];
    wire        full_hs   = en & ctrl_q[pshp_pkg::FULL_HS_BIT];
    wire        dir_out   = ctrl_q[pshp_pkg::DIR_BIT];
    wire        out_hs    = full_hs & dir_out;
    wire        in_hs     = full_hs & ~dir_out;
    wire        pulsed    = ctrl_q[pshp_pkg::PULSED_BIT];
    wire        edge_sel  = ctrl_q[pshp_pkg::EDGE_BIT];
    wire        od_sel    = ctrl_q[pshp_pkg::OD_BIT];
    wire        tri_var   = out_hs & (ddr_q == pshp_pkg::BYTE_RESET);

    ////////////////////////////////////////////////////////////////////
    // Strobe A edges
    // Falling edge on 0
    wire        act_edge  = en & (edge_sel ? link.strobe_a_in_rise
                                           : link.strobe_a_in_fall);
    wire        trail     = en & (edge_sel ? link.strobe_a_in_fall
                                           : link.strobe_a_in_rise);
    wire        act_lvl   = edge_sel ? ~link.strobe_a_in_level
                                     : link.strobe_a_in_level;

    ////////////////////////////////////////////////////////////////////
    // Flag sequence
    wire        latch_rd  = rd & hit_latch;
    wire        latch_wr  = wr & hit_latch;
    wire        arm_set   = rd & hit_ctrl & prdata_q[pshp_pkg::FLAG_BIT];
    wire        flag_clr  = armed_q & (out_hs ? latch_wr : latch_rd);

    assign flag_d  = act_edge | (flag_q & ~flag_clr);
    assign armed_d = arm_set | (armed_q & ~flag_clr);

    ////////////////////////////////////////////////////////////////////
    // Strobe B control
    wire        in_enter  = in_hs & ~in_hs_q;
    wire        sb_simple = en & ~full_hs & wr & hit_pb;
    wire        sb_in     = in_hs & (in_enter | latch_rd);
    wire        sb_out    = out_hs & latch_wr;
    wire        sb_end    = full_hs & ~pulsed
                          & (tri_var ? trail : act_edge);

    assign link.sb_start    = sb_simple | sb_in | sb_out;
    assign link.sb_stop     = ~en | sb_end;
    assign link.sb_pulsed   = ~full_hs | pulsed;
    assign link.sb_polarity = ctrl_q[pshp_pkg::POL_BIT];

    ////////////////////////////////////////////////////////////////////
    // Port C drive
    // Output handshake drive
    wire [7:0]  drv       = ddr_q | {8{out_hs & act_lvl}};
    wire [7:0]  pc_out_d  = od_sel ? pshp_pkg::BYTE_RESET : pc_data_q;
    wire [7:0]  pc_oe_d   = od_sel ? (drv & ~pc_data_q) : drv;
    wire [7:0]  pc_rd     = (ddr_q & pc_data_q) | (~ddr_q & port_c_in);

    ////////////////////////////////////////////////////////////////////
    // Interrupts
    wire [1:0]  st_set    = {link.sb_start, act_edge};
    wire [1:0]  st_clr    = (wr & hit_st) ? pwdata[1:0] : 2'h0;
    assign st_d = st_set | (st_q & ~st_clr);
    wire        irq_d     = (flag_d & ctrl_q[pshp_pkg::IRQ_EN_BIT])
                          | (|(st_d & mask_q));

    ////////////////////////////////////////////////////////////////////
    // Read mux
    // Flag read-only
    wire [31:0] rd_data   =
        hit_ctrl  ? {24'h000000, flag_q, ctrl_q} :
        hit_pb    ? {24'h000000, pb_q} :
        hit_pc    ? {24'h000000, pc_rd} :
        hit_latch ? {24'h000000, latch_q} :
        hit_ddr   ? {24'h000000, ddr_q} :
        hit_st    ? {30'h0, st_q} :
        hit_mask  ? {30'h0, mask_q} :
        hit_mode  ? {31'h0, mode_q} :
                    pshp_pkg::WORD_ZERO;

    ////////////////////////////////////////////////////////////////////
    // Bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= pshp_pkg::WORD_ZERO;
        end else if (setup) begin
            prdata_q <= pwrite ? pshp_pkg::WORD_ZERO : rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control and mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= pshp_pkg::CTRL_RESET;
        end else if (wr && hit_ctrl) begin
            ctrl_q <= pwdata[6:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= pshp_pkg::MODE_RESET;
        end else if (wr && hit_mode) begin
            mode_q <= pwdata[0:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q  <= 1'b0;
            armed_q <= 1'b0;
            in_hs_q <= 1'b0;
        end else begin
            flag_q  <= flag_d;
            armed_q <= armed_d;
            in_hs_q <= in_hs;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb_q <= pshp_pkg::BYTE_RESET;
        end else if (wr && hit_pb) begin
            pb_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ddr_q <= pshp_pkg::BYTE_RESET;
        end else if (wr && hit_ddr) begin
            ddr_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_data_q <= pshp_pkg::BYTE_RESET;
        end else if ((wr && hit_pc) || (latch_wr && out_hs)) begin
            pc_data_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= pshp_pkg::BYTE_RESET;
        end else if (latch_wr && out_hs) begin
            latch_q <= pwdata[7:0];
        end else if (act_edge && !out_hs) begin
            latch_q <= port_c_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= 2'h0;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 2'h0;
        end else if (wr && hit_mask) begin
            mask_q <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_out_q <= pshp_pkg::BYTE_RESET;
            pc_oe_q  <= pshp_pkg::BYTE_RESET;
            irq_q    <= 1'b0;
        end else begin
            pc_out_q <= pc_out_d;
            pc_oe_q  <= pc_oe_d;
            irq_q    <= irq_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign strobe_b_out = link.sb_level;
    assign port_b_out   = pb_q;
    assign port_c_out   = pc_out_q;
    assign port_c_oe    = pc_oe_q;
    assign irq          = irq_q;
endmodule

/* File: tb/pshp_ext_model.sv */
/*
 External parallel system: drives strobe A and port C pins.
 Assumes the bench tells it the strobe B active level.
*/
`timescale 1ns/10ps
module pshp_ext_model (
    // Clock and observed strobe
    input  wire logic       pclk,
    input  wire logic       strobe_b_out,
    input  wire logic       sb_active,
    // Driven pins
    output logic            strobe_a_in,
    output logic      [7:0] port_c_in
);
    logic sb_timeout = 1'b0;
    initial begin
        strobe_a_in = 1'b1;
        port_c_in   = 8'h00;
    end
    // Wait for strobe B, present data, acknowledge
    task automatic strobe(input logic [7:0] data, input logic wait_sb, input int hold);
        int i;
        i = 0;
        while (wait_sb && strobe_b_out !== sb_active && i < 50) begin
            @(posedge pclk);
            i++;
        end
        if (wait_sb && strobe_b_out !== sb_active) sb_timeout = 1'b1;
        @(posedge pclk);
        port_c_in   <= data;
        strobe_a_in <= 1'b0;
        repeat (hold) @(posedge pclk);
        strobe_a_in <= 1'b1;
        repeat (hold) @(posedge pclk);
        port_c_in   <= ~data;
    endtask
endmodule

/* File: tb/pshp_properties.sv */
/*
 Checker for pshp_top: APB timing, strobe B pulses, port C drive, interrupt.
 Assumes it is bound to pshp_top; control, mask and mode are shadowed from APB writes.
*/
`timescale 1ns/10ps
module pshp_properties (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        strobe_a_in,
    input wire logic        strobe_b_out,
    input wire logic [7:0]  port_b_out,
    input wire logic [7:0]  port_c_out,
    input wire logic [7:0]  port_c_oe,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [6:0] ctrl_q;
    logic [1:0] mask_q;
    logic       single_q;
    logic       sb_q;
    logic [3:0] run_q;
    logic [3:0] quiet_q;
    logic       wr;
    logic       rd;
    logic       pulsed;
    assign wr     = psel & penable & pready & pwrite;
    assign rd     = psel & penable & pready & !pwrite;
    assign pulsed = single_q & (!ctrl_q[4] | ctrl_q[2]);
    ////////////////////////////////////////////////////////////////////
    // Shadows and strobe B run length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= pshp_pkg::CTRL_RESET;
            mask_q   <= 2'h0;
            single_q <= 1'b1;
            sb_q     <= 1'b0;
            run_q    <= 4'h0;
            quiet_q  <= 4'h0;
        end else begin
            if (wr && paddr == pshp_pkg::CTRL_OFF) ctrl_q <= pwdata[6:0];
            if (wr && paddr == pshp_pkg::IRQ_MASK_OFF) mask_q <= pwdata[1:0];
            if (wr && paddr == pshp_pkg::MODE_OFF) single_q <= pwdata[0];
            sb_q    <= strobe_b_out;
            run_q   <= (strobe_b_out != sb_q) ? 4'h1 : run_q + {3'h0, run_q != 4'hF};
            quiet_q <= (wr && paddr == pshp_pkg::CTRL_OFF) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
        end
    end
    ////////////////////////////////////////////////////////////////////
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_unmapped_err: assert property (pready && paddr > pshp_pkg::MODE_OFF |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ctrl_read: assert property (rd && paddr == pshp_pkg::CTRL_OFF |->
        prdata[6:0] == ctrl_q && prdata[31:8] == 24'h0)
        else $error("control readback mismatch");
    a_port_b_data: assert property (wr && paddr == pshp_pkg::PB_DATA_OFF |=> port_b_out == $past(pwdata[7:0]))
        else $error("port B data not written");
    a_pb_strobe: assert property (wr && paddr == pshp_pkg::PB_DATA_OFF && single_q && !ctrl_q[4]
        && quiet_q > 4'h3 |-> ##[1:3] strobe_b_out == ctrl_q[0])
        else $error("strobe B missing after port B write");
    a_pulse_two: assert property (strobe_b_out != sb_q && sb_q == ctrl_q[0] && pulsed
        && quiet_q > 4'h3 |-> run_q == 4'h2)
        else $error("strobe B pulse length wrong");
    a_irq_quiet: assert property ((!ctrl_q[6] && mask_q == 2'h0) [*3] |-> !irq)
        else $error("interrupt without enable");
    a_open_drain: assert property (ctrl_q[5] [*2] |-> port_c_out == 8'h00)
        else $error("open-drain port C drives high");
    a_out_drive: assert property ((single_q && ctrl_q[4] && ctrl_q[3] && !ctrl_q[5]
        && strobe_a_in != ctrl_q[1]) [*4] |-> port_c_oe == 8'hFF)
        else $error("port C not driven at strobe A active level");
    a_mode_off: assert property ((!single_q && quiet_q > 4'h2) [*2] |-> strobe_b_out != ctrl_q[0])
        else $error("strobe B active outside single-chip mode");
    c_pb_write: cover property (wr && paddr == pshp_pkg::PB_DATA_OFF);
    c_latch_read: cover property (rd && paddr == pshp_pkg::PC_LATCH_OFF);
    c_irq: cover property (irq);
endmodule
bind pshp_top pshp_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strobe_a_in(strobe_a_in), .strobe_b_out(strobe_b_out), .port_b_out(port_b_out),
    .port_c_out(port_c_out), .port_c_oe(port_c_oe), .irq(irq));

/* File: tb/pshp_top_tb.sv */
/*
 Self-checking bench for pshp_top: registers, strobes, port C, interrupt.
 Assumes the external model drives strobe A and port C pins.
*/
`timescale 1ns/10ps
module pshp_top_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        strobe_a_in;
    logic        strobe_b_out;
    logic [7:0]  port_b_out;
    logic [7:0]  port_c_in;
    logic [7:0]  port_c_out;
    logic [7:0]  port_c_oe;
    logic        irq;
    logic        sb_pol = 1'b1;
    logic [31:0] rdata;
    logic        err;
    logic [31:0] d;
    int          sb_cnt;
    int          failures = 0;
    int          comparisons = 0;
    always #5 pclk = ~pclk;
    pshp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strobe_a_in(strobe_a_in), .strobe_b_out(strobe_b_out), .port_b_out(port_b_out),
        .port_c_in(port_c_in), .port_c_out(port_c_out), .port_c_oe(port_c_oe), .irq(irq));
    pshp_ext_model u_ext (.pclk(pclk), .strobe_b_out(strobe_b_out), .sb_active(sb_pol),
        .strobe_a_in(strobe_a_in), .port_c_in(port_c_in));
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            failures++;
            print_verdict();
        end
        rdata   = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rdata);
    endtask
    task automatic count_sb();
        sb_cnt = 0;
        repeat (8) begin
            @(negedge pclk);
            if (strobe_b_out === sb_pol) sb_cnt++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        d = $urandom(10);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl reset", pshp_pkg::CTRL_OFF, {25'h0, pshp_pkg::CTRL_RESET});
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'hFF);
        rd_chk("ctrl flag ro", pshp_pkg::CTRL_OFF, 32'h7F);
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'h03);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        for (int p = 0; p < 2; p++) begin
            sb_pol = p[0];
            apb(1'b1, pshp_pkg::CTRL_OFF, {30'h0, 1'b1, sb_pol});
            repeat (3) @(posedge pclk);
            d = $urandom;
            apb(1'b1, pshp_pkg::PB_DATA_OFF, d);
            count_sb();
            check("port b strobe", 32'h2, sb_cnt);
            check("port b data", {24'h0, d[7:0]}, {24'h0, port_b_out});
        end
        sb_pol = 1'b1;
        for (int e = 0; e < 2; e++) begin
            d = $urandom;
            apb(1'b1, pshp_pkg::CTRL_OFF, e ? 32'h0B : 32'h49);
            apb(1'b1, pshp_pkg::IRQ_ST_OFF, 32'h3);
            u_ext.strobe(d[7:0], 1'b0, 5 + $urandom % 4);
            repeat (6) @(negedge pclk);
            check("irq flag", e ? 32'h0 : 32'h1, {31'h0, irq});
            rd_chk("latch early", pshp_pkg::PC_LATCH_OFF, {24'h0, d[7:0]});
            rd_chk("flag set", pshp_pkg::CTRL_OFF, e ? 32'h8B : 32'hC9);
            rd_chk("latch", pshp_pkg::PC_LATCH_OFF, {24'h0, d[7:0]});
            rd_chk("flag clear", pshp_pkg::CTRL_OFF, e ? 32'h0B : 32'h49);
            rd_chk("status", pshp_pkg::IRQ_ST_OFF, 32'h1);
            repeat (3) @(negedge pclk);
            check("irq cleared", 32'h0, {31'h0, irq});
        end
        apb(1'b1, pshp_pkg::IRQ_MASK_OFF, 32'h1);
        repeat (3) @(negedge pclk);
        check("irq masked in", 32'h1, {31'h0, irq});
        apb(1'b1, pshp_pkg::IRQ_ST_OFF, 32'h1);
        repeat (3) @(negedge pclk);
        check("irq w1c", 32'h0, {31'h0, irq});
        apb(1'b1, pshp_pkg::IRQ_MASK_OFF, 32'h0);
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'h11);
        repeat (3) @(negedge pclk);
        check("sb ready", 32'h1, {31'h0, strobe_b_out});
        d = $urandom;
        u_ext.strobe(d[7:0], 1'b1, 5 + $urandom % 4);
        repeat (3) @(negedge pclk);
        check("sb released", 32'h0, {31'h0, strobe_b_out});
        rd_chk("hs flag", pshp_pkg::CTRL_OFF, 32'h91);
        rd_chk("hs latch", pshp_pkg::PC_LATCH_OFF, {24'h0, d[7:0]});
        repeat (3) @(negedge pclk);
        check("sb rearmed", 32'h1, {31'h0, strobe_b_out});
        rd_chk("status hs", pshp_pkg::IRQ_ST_OFF, 32'h3);
        apb(1'b1, pshp_pkg::PC_DIR_OFF, 32'h0);
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'h1D);
        d = $urandom;
        apb(1'b1, pshp_pkg::PC_LATCH_OFF, d);
        count_sb();
        check("out pulse", 32'h2, sb_cnt);
        check("pc drive", 32'hFF, {24'h0, port_c_oe});
        check("pc data", {24'h0, d[7:0]}, {24'h0, port_c_out});
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'h3D);
        repeat (3) @(negedge pclk);
        check("od data", 32'h0, {24'h0, port_c_out});
        check("od enable", {24'h0, ~d[7:0]}, {24'h0, port_c_oe});
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'h1F);
        repeat (3) @(negedge pclk);
        check("pc follows dir", 32'h0, {24'h0, port_c_oe});
        u_ext.strobe(8'h00, 1'b0, 5);
        repeat (3) @(negedge pclk);
        rd_chk("out flag", pshp_pkg::CTRL_OFF, 32'h9F);
        apb(1'b1, pshp_pkg::PC_LATCH_OFF, d);
        rd_chk("out flag clear", pshp_pkg::CTRL_OFF, 32'h1F);
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'h19);
        apb(1'b1, pshp_pkg::PC_LATCH_OFF, d);
        repeat (6) @(negedge pclk);
        check("ol held", 32'h1, {31'h0, strobe_b_out});
        u_ext.strobe(d[7:0], 1'b1, 5);
        repeat (3) @(negedge pclk);
        check("ol released", 32'h0, {31'h0, strobe_b_out});
        apb(1'b1, pshp_pkg::CTRL_OFF, 32'h03);
        apb(1'b1, pshp_pkg::MODE_OFF, 32'h0);
        apb(1'b1, pshp_pkg::PB_DATA_OFF, $urandom);
        count_sb();
        check("mode off", 32'h0, sb_cnt);
        check("model wait", 32'h0, {31'h0, u_ext.sb_timeout});
        print_verdict();
    end
endmodule
